/* File: csd_pkg.sv */
// Purpose: constants for clock select and oscillation stop detection
// Assumes: one 200 MHz system clock, oscillators seen as tick pulses
// Notes: no timescale here, packages carry none
package csd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // clock mode register layout
  localparam logic [7:0] CM_RESET = 8'h80; // internal osc, both running
  localparam logic [7:0] CM_LOCK_MASK = 8'h23; // bits 5, 1, 0
  localparam logic [7:0] CM_FREE_MASK = 8'hdc; // bits 7, 6, 4, 3, 2
  localparam int CM_DIV_HI = 7;
  localparam int CM_DIV_LO = 6;
  localparam int CM_RC_MODE = 5;
  localparam int CM_XIN_STOP = 4;
  localparam int CM_ROSC_STOP = 3;

  // divider select field codes
  localparam logic [1:0] CM_DIV_HIGH = 2'h0; // xin / 2
  localparam logic [1:0] CM_DIV_MID = 2'h1; // xin / 8
  localparam logic [1:0] CM_DIV_ROSC = 2'h2; // internal oscillator
  localparam logic [1:0] CM_DIV_DBL = 2'h3; // xin / 1, ceramic only

  ////////////////////////////////////////////////////////////////////////
  // internal oscillator division ratio select codes
  localparam logic [1:0] RD_DIV1 = 2'h0;
  localparam logic [1:0] RD_DIV2 = 2'h1;
  localparam logic [1:0] RD_DIV8 = 2'h2;
  localparam logic [1:0] RD_DIV128 = 2'h3;

  // divider terminal counts, ratio minus one
  localparam logic [6:0] LAST_1 = 7'h00;
  localparam logic [6:0] LAST_2 = 7'h01;
  localparam logic [6:0] LAST_8 = 7'h07;
  localparam logic [6:0] LAST_128 = 7'h7f;

  ////////////////////////////////////////////////////////////////////////
  // supervision register layout
  localparam int MS_ACTIVE = 0;
  localparam int MS_RST_EN = 1;
  localparam int MS_STATUS = 2;

  // internal oscillator ticks without an xin tick that mean "stopped"
  localparam logic [7:0] STOP_LIMIT = 8'h20;

endpackage

/* File: csd_div_if.sv */
// Purpose: carrier between the clock controller and a tick divider
// Assumes: all signals in the system clock domain
// Notes: one instance per divider
`timescale 1ns/1ps
interface csd_div_if;
  logic tick_in; // source oscillator tick
  logic [6:0] last; // ratio minus one
  logic clear; // restart count
  logic tick_out; // divided tick, registered

  modport ctrl (output tick_in, output last, output clear,
                input tick_out);
  modport div (input tick_in, input last, input clear,
               output tick_out);
endinterface

/* File: csd_divider.sv */
// Purpose: divide a tick stream by a selectable ratio
// Assumes: tick_in is a one-cycle pulse per source cycle
// Notes: a ratio change takes effect at the next wrap or at once
`timescale 1ns/1ps
module csd_divider
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  csd_div_if.div bus
);

  logic [6:0] cnt_r; // source ticks seen in this period
  logic tick_r; // registered divided tick
  logic wrap; // terminal count reached on a tick

  // >= so a lowered ratio never leaves the counter stranded
  assign wrap = bus.tick_in && (cnt_r >= bus.last);

  ////////////////////////////////////////////////////////////////////////
  // period counter
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_r <= 7'h00;
    else if (bus.clear || wrap)
      cnt_r <= 7'h00;
    else if (bus.tick_in)
      cnt_r <= cnt_r + 7'h01;
  end

  // output tick, one cycle per period
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tick_r <= 1'b0;
    else
      tick_r <= wrap && !bus.clear;
  end

  assign bus.tick_out = tick_r;

endmodule // csd_divider

/* File: csd_stop_det.sv */
// Purpose: watch xin ticks using internal oscillator ticks
// Assumes: both ticks are one-cycle pulses in the system clock
// Notes: with the internal oscillator halted nothing is ever flagged
`timescale 1ns/1ps
module csd_stop_det
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_xin_tick,
  input wire logic i_rosc_tick,
  output logic o_stopped
);

  logic [7:0] gap_r; // internal ticks since the last xin tick
  logic stopped_r; // registered detection level

  ////////////////////////////////////////////////////////////////////////
  // gap counter, saturating at the limit
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      gap_r <= 8'h00;
    else if (!i_enable || i_xin_tick)
      gap_r <= 8'h00;
    else if (i_rosc_tick && gap_r != csd_pkg::STOP_LIMIT)
      gap_r <= gap_r + 8'h01; // only internal ticks advance it
  end

  // detection level
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      stopped_r <= 1'b0;
    else
      stopped_r <= i_enable && (gap_r == csd_pkg::STOP_LIMIT);
  end

  assign o_stopped = stopped_r;

endmodule // csd_stop_det

/* File: csd_clock_ctrl.sv */
// Purpose: cpu clock source select, dividers and stop supervision
// Assumes: oscillators arrive as synchronous one-cycle tick pulses
// Notes: reset requests from other sources arrive as sync pulses
`timescale 1ns/1ps
module csd_clock_ctrl
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_xin_tick,
  input wire logic i_rosc_tick,
  input wire logic i_cm_wr,
  input wire logic [7:0] i_cm_wdata,
  input wire logic i_cm_rmw,
  input wire logic [2:0] i_cm_rmw_bit,
  input wire logic i_rd_wr,
  input wire logic [1:0] i_rd_wdata,
  input wire logic i_ms_wr,
  input wire logic [7:0] i_ms_wdata,
  input wire logic i_wdt_underflow,
  input wire logic i_ext_rst,
  input wire logic i_lvd_rst,
  input wire logic i_wdt_rst,
  input wire logic i_stp_rst,
  output logic [7:0] o_cm_rdata,
  output logic [1:0] o_rd_rdata,
  output logic [7:0] o_ms_rdata,
  output logic o_cpu_tick,
  output logic o_wdt_tick,
  output logic o_periph_tick,
  output logic o_xin_osc_en,
  output logic o_rosc_en,
  output logic o_rc_mode,
  output logic o_osc_stop_rst
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] cm_r; // clock mode register
  logic lock_r; // bits 5, 1, 0 frozen
  logic [1:0] rdiv_r; // internal division ratio select
  logic active_r; // detector active
  logic rst_en_r; // stop reset enable
  logic status_r; // stop seen
  logic cpu_tick_r; // registered cpu tick
  logic src_tick_r; // registered source tick
  logic sys_rst; // any synchronous chip reset
  logic other_rst; // resets except the stop reset
  logic rosc_sel; // internal oscillator clocks the cpu
  logic rmw_other; // bit op aimed at a free bit
  logic [1:0] div_new; // divider field after a write
  logic enter_rosc; // xin to internal switch this cycle
  logic [6:0] xin_last; // xin ratio minus one
  logic [6:0] rosc_last; // internal ratio minus one
  logic det_stop; // detector says xin stopped
  logic stat_set; // status set event
  logic stat_clr; // status clear by write
  logic [7:0] lock_part; // next value of the locked bits

  csd_div_if xin_if();
  csd_div_if rosc_if();

  ////////////////////////////////////////////////////////////////////////
  // reset gathering
  assign other_rst = i_ext_rst || i_lvd_rst || i_wdt_rst || i_stp_rst;
  // stop reset folds in so all but the active and status bits restart with the chip
  assign sys_rst = other_rst || o_osc_stop_rst;

  ////////////////////////////////////////////////////////////////////////
  // clock mode register write path
  assign rmw_other = i_cm_rmw
                     && csd_pkg::CM_FREE_MASK[i_cm_rmw_bit];
  // a locked write or a bit op on a free bit keeps the stored mode bits
  assign lock_part = (lock_r || rmw_other)
                     ? (cm_r & csd_pkg::CM_LOCK_MASK)
                     : (i_cm_wdata & csd_pkg::CM_LOCK_MASK);
  assign div_new = i_cm_wdata[csd_pkg::CM_DIV_HI:csd_pkg::CM_DIV_LO];

  // register contents
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cm_r <= csd_pkg::CM_RESET;
    else if (sys_rst)
      cm_r <= csd_pkg::CM_RESET;
    else if (i_cm_wr)
      cm_r <= (i_cm_wdata & csd_pkg::CM_FREE_MASK) | lock_part;
  end

  // write-once lock; any first write, plain or bit op, closes it
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      lock_r <= 1'b0;
    else if (sys_rst)
      lock_r <= 1'b0;
    else if (i_cm_wr)
      lock_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // source selection
  assign rosc_sel = (cm_r[csd_pkg::CM_DIV_HI:csd_pkg::CM_DIV_LO]
                     == csd_pkg::CM_DIV_ROSC);
  assign enter_rosc = i_cm_wr && !rosc_sel
                      && (div_new == csd_pkg::CM_DIV_ROSC);

  // internal division ratio; a switch to internal forces divide by 8
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdiv_r <= csd_pkg::RD_DIV8;
    else if (sys_rst)
      rdiv_r <= csd_pkg::RD_DIV8;
    else if (enter_rosc)
      rdiv_r <= csd_pkg::RD_DIV8; // forced value wins the cycle
    else if (i_rd_wr)
      rdiv_r <= i_rd_wdata;
  end

  // xin ratio from the divider field
  always_comb
  begin
    case (cm_r[csd_pkg::CM_DIV_HI:csd_pkg::CM_DIV_LO])
      csd_pkg::CM_DIV_HIGH:
        xin_last = csd_pkg::LAST_2;
      csd_pkg::CM_DIV_MID:
        xin_last = csd_pkg::LAST_8;
      csd_pkg::CM_DIV_DBL:
        // double speed is unsafe with rc, fall back to divide by 2
        xin_last = cm_r[csd_pkg::CM_RC_MODE] ? csd_pkg::LAST_2
                                             : csd_pkg::LAST_1;
      default:
        xin_last = csd_pkg::LAST_8; // unused while internal selected
    endcase
  end

  // internal ratio from the select register
  always_comb
  begin
    case (rdiv_r)
      csd_pkg::RD_DIV1:
        rosc_last = csd_pkg::LAST_1;
      csd_pkg::RD_DIV2:
        rosc_last = csd_pkg::LAST_2;
      csd_pkg::RD_DIV8:
        rosc_last = csd_pkg::LAST_8;
      default:
        rosc_last = csd_pkg::LAST_128;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // dividers, one per oscillator
  assign xin_if.tick_in = i_xin_tick;
  assign xin_if.last = xin_last;
  assign xin_if.clear = sys_rst;
  assign rosc_if.tick_in = i_rosc_tick;
  assign rosc_if.last = rosc_last;
  assign rosc_if.clear = sys_rst;

  csd_divider u_xin_div
  (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .bus (xin_if.div)
  );

  csd_divider u_rosc_div
  (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .bus (rosc_if.div)
  );

  // cpu tick from the selected divider
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cpu_tick_r <= 1'b0;
    else
      cpu_tick_r <= rosc_sel ? rosc_if.tick_out
                             : xin_if.tick_out;
  end

  // undivided source tick for watchdog and peripherals
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      src_tick_r <= 1'b0;
    else
      src_tick_r <= rosc_sel ? i_rosc_tick : i_xin_tick;
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator run controls; the selected source can never be stopped
  assign o_xin_osc_en = !(cm_r[csd_pkg::CM_XIN_STOP]
                          && rosc_sel);
  assign o_rosc_en = !(cm_r[csd_pkg::CM_ROSC_STOP]
                       && !rosc_sel);

  ////////////////////////////////////////////////////////////////////////
  // stop detector
  csd_stop_det u_det
  (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_enable (active_r),
    .i_xin_tick (i_xin_tick),
    .i_rosc_tick (i_rosc_tick),
    .o_stopped (det_stop)
  );

  // watchdog underflow is a known false trigger while active
  assign stat_set = active_r && (det_stop || i_wdt_underflow);
  assign stat_clr = i_ms_wr && !i_ms_wdata[csd_pkg::MS_ACTIVE];

  // detector active bit, kept across its own reset
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      active_r <= 1'b0;
    else if (i_ext_rst)
      active_r <= 1'b0;
    else if (i_ms_wr)
      active_r <= i_ms_wdata[csd_pkg::MS_ACTIVE];
  end

  // stop reset enable, cleared by every reset so it cannot loop
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_en_r <= 1'b0;
    else if (sys_rst)
      rst_en_r <= 1'b0;
    else if (i_ms_wr)
      rst_en_r <= i_ms_wdata[csd_pkg::MS_RST_EN];
  end

  // status; set beats a clear in the same cycle
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      status_r <= 1'b0;
    else if (other_rst)
      status_r <= 1'b0;
    else if (stat_set)
      status_r <= 1'b1;
    else if (stat_clr)
      status_r <= 1'b0;
  end

  // internal reset whenever enabled with a retained stop
  assign o_osc_stop_rst = active_r && status_r && rst_en_r;

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_cm_rdata = cm_r;
  assign o_rd_rdata = rdiv_r;
  assign o_ms_rdata = {5'h00, status_r, rst_en_r, active_r};
  assign o_cpu_tick = cpu_tick_r;
  assign o_wdt_tick = src_tick_r;
  assign o_periph_tick = src_tick_r; // divider never touches it
  assign o_rc_mode = cm_r[csd_pkg::CM_RC_MODE];

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_lock_holds: assert property (
    lock_r && !sys_rst |=> $stable(cm_r & csd_pkg::CM_LOCK_MASK))
    else $error("locked mode bits changed");

  a_rmw_locks: assert property (
    i_cm_wr && rmw_other && !sys_rst
    |=> lock_r && $stable(cm_r & csd_pkg::CM_LOCK_MASK))
    else $error("bit op did not lock mode bits");

  a_reset_div8: assert property (
    sys_rst |=> rdiv_r == csd_pkg::RD_DIV8 && rosc_sel)
    else $error("reset did not pick internal divide by 8");

  a_enter_div8: assert property (
    enter_rosc && !sys_rst |=> rosc_sel && rdiv_r == csd_pkg::RD_DIV8)
    else $error("switch to internal not divide by 8");

  a_wdt_follow: assert property (
    ##1 o_wdt_tick == $past(rosc_sel ? i_rosc_tick : i_xin_tick))
    else $error("watchdog source not following cpu source");

  a_status_set: assert property (
    active_r && det_stop && !other_rst |=> status_r)
    else $error("stop not flagged");

  a_stop_reset: assert property (
    o_osc_stop_rst |=> !rst_en_r && active_r && !o_osc_stop_rst)
    else $error("stop reset not single or lost bits");

  a_write_clear: assert property (
    stat_clr && !stat_set |=> !status_r)
    else $error("active zero did not clear status");

  a_ext_clear: assert property (
    i_ext_rst |=> !active_r && !status_r)
    else $error("external reset kept detector bits");

  a_sel_runs: assert property (
    (rosc_sel |-> o_rosc_en) and (!rosc_sel |-> o_xin_osc_en))
    else $error("selected oscillator disabled");

  a_div1_rc: assert property (
    cm_r[csd_pkg::CM_RC_MODE] |-> xin_last != csd_pkg::LAST_1)
    else $error("double speed used with rc oscillation");

  c_status: cover property (active_r && det_stop ##1 status_r);
  c_stop_rst: cover property (o_osc_stop_rst);
  c_enter: cover property (enter_rosc ##1 rosc_sel);
  c_lock: cover property (lock_r && i_cm_wr);

endmodule // csd_clock_ctrl

/* File: csd_osc_model.sv */
// Purpose: oscillator model, xin resonator and internal oscillator
// Assumes: ticks are one-cycle pulses in the 200 MHz system clock
// Notes: a halted or broken oscillator gives no ticks at all
`timescale 1ns/1ps
module csd_osc_model
#(
  parameter int XP = 3, // xin tick spacing in cycles
  parameter int RP = 4 // internal tick spacing in cycles
)
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_xin_run, // low models a broken resonator
  input wire logic i_xin_en,
  input wire logic i_rosc_en,
  output logic o_xin_tick,
  output logic o_rosc_tick
);
  int xc; // xin phase counter
  int rc; // internal phase counter

  ////////////////////////////////////////////////////////////////////////
  // xin swings only while enabled and not broken
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      xc <= 0;
      o_xin_tick <= 1'b0;
    end
    else
    begin
      xc <= (xc == XP - 1) ? 0 : xc + 1;
      o_xin_tick <= i_xin_run && i_xin_en && xc == 0;
    end
  end

  // internal oscillator stops dead when its enable drops
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rc <= 0;
      o_rosc_tick <= 1'b0;
    end
    else
    begin
      rc <= (rc == RP - 1) ? 0 : rc + 1;
      o_rosc_tick <= i_rosc_en && rc == 0;
    end
  end
endmodule // csd_osc_model

/* File: testbench.sv */
// Purpose: self-checking bench for the clock controller
// Assumes: xin ticks every 3 cycles, internal ticks every 4
// Notes: bit op writes name bit 2 unless a scenario retargets them
`timescale 1ns/1ps
module testbench;
  localparam int XP = 3; // xin tick spacing
  localparam int RP = 4; // internal tick spacing
  logic i_clock;
  logic i_rst_n;
  logic [8:0] stb; // one strobe per request kind
  logic [7:0] wd; // shared write data
  logic [2:0] rb; // bit op target bit
  logic xin_run; // low breaks the resonator
  logic xt, rt, xen, ren;
  logic [7:0] cm, ms;
  logic [1:0] rd;
  logic cpu, wdt, prt, rcm, srst;
  int err_total;
  int comparisons;

  csd_clock_ctrl u_csd_clock_ctrl (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_xin_tick(xt), .i_rosc_tick(rt), .i_cm_wr(stb[0] | stb[3]),
    .i_cm_wdata(wd), .i_cm_rmw(stb[3]), .i_cm_rmw_bit(rb),
    .i_rd_wr(stb[1]), .i_rd_wdata(wd[1:0]), .i_ms_wr(stb[2]),
    .i_ms_wdata(wd), .i_wdt_underflow(stb[8]), .i_ext_rst(stb[4]),
    .i_lvd_rst(stb[5]), .i_wdt_rst(stb[6]), .i_stp_rst(stb[7]),
    .o_cm_rdata(cm), .o_rd_rdata(rd), .o_ms_rdata(ms), .o_cpu_tick(cpu),
    .o_wdt_tick(wdt), .o_periph_tick(prt), .o_xin_osc_en(xen),
    .o_rosc_en(ren), .o_rc_mode(rcm), .o_osc_stop_rst(srst));
  csd_osc_model #(.XP(XP), .RP(RP)) u_csd_osc_model (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_xin_run(xin_run), .i_xin_en(xen),
    .i_rosc_en(ren), .o_xin_tick(xt), .o_rosc_tick(rt));

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic tk(input int s);
    return s == 0 ? cpu : (s == 1 ? wdt : prt);
  endfunction

  task automatic idle(input int k);
    repeat (k) @(posedge i_clock);
    #1;
  endtask

  // one strobe for one cycle; kinds 4..7 are sync resets, 8 underflow
  task automatic put(input int p, input logic [7:0] d);
    idle(1);
    wd = d;
    stb[p] = 1'b1;
    idle(1);
    stb = '0;
  endtask

  // cycles from one tick to the next; bounded so a dead tick ends it
  task automatic per(input int s, output logic [15:0] n);
    int k;
    k = 0;
    n = 0;
    while (tk(s) !== 1'b1 && k < 2000)
    begin
      idle(1);
      k++;
    end
    do
    begin
      idle(1);
      n++;
    end while (tk(s) !== 1'b1 && n < 2000);
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    logic [15:0] n;
    chk("cm", cm, 8'h80);
    chk("rd", rd, 2'h2);
    chk("ms", ms, 8'h00);
    chk("osc_en", {xen, ren}, 2'h3);
    per(0, n);
    per(0, n);
    chk("cpu_per", n, 16'(8 * RP));
  endtask

  // first write locks; a bit op elsewhere locks as well
  task automatic t_lock();
    put(0, 8'h21);
    chk("cm", cm, 8'h21);
    chk("rc_mode", rcm, 1'b1);
    put(0, 8'h80);
    chk("cm", cm, 8'ha1);
    put(4, 8'h00);
    chk("cm", cm, 8'h80);
    put(3, 8'h84);
    chk("cm", cm, 8'h84);
    put(0, 8'ha3);
    chk("cm", cm, 8'h80);
    put(4, 8'h00);
    rb = 3'h5; // bit op on a mode bit is itself the one write
    put(3, 8'ha0);
    chk("cm", cm, 8'ha0);
    rb = 3'h2;
    put(0, 8'h80);
    chk("cm", cm, 8'ha0);
    put(4, 8'h00);
  endtask

  task automatic t_rdiv();
    logic [15:0] n;
    int sh [4] = '{0, 1, 3, 7};
    for (int c = 0; c < 4; c++)
    begin
      put(1, 8'(c));
      per(0, n);
      per(0, n);
      chk("rosc_cpu_per", n, 16'(RP << sh[c]));
      per(2, n);
      chk("periph_per", n, 16'(RP));
    end
    put(1, 8'h02);
  endtask

  // xin speeds, return to internal, stop bits, dead internal oscillator
  task automatic t_xin();
    logic [15:0] n;
    logic [7:0] cv [3] = '{8'h00, 8'h40, 8'hc0};
    int mul [3] = '{2, 8, 1};
    for (int c = 0; c < 3; c++)
    begin
      put(0, cv[c]);
      per(0, n);
      per(0, n);
      chk("xin_cpu_per", n, 16'(XP * mul[c]));
      per(1, n);
      chk("wdt_per", n, 16'(XP));
    end
    put(1, 8'h03);
    put(0, 8'h80);
    chk("rd", rd, 2'h2);
    per(0, n);
    per(0, n);
    chk("rosc_cpu_per", n, 16'(8 * RP));
    per(1, n);
    chk("wdt_per", n, 16'(RP));
    idle(3); // settle time after leaving double speed
    put(0, 8'h98);
    chk("osc_en", {xen, ren}, 2'h1);
    put(0, 8'h80);
    idle(20); // xin must be stable before it takes over
    put(0, 8'h00);
    idle(4); // settle time before halting internal
    put(0, 8'h08);
    chk("osc_en", {xen, ren}, 2'h2);
    put(2, 8'h00);
    put(2, 8'h03);
    xin_run = 1'b0;
    idle(300);
    chk("ms", ms, 8'h03);
    chk("cm", cm, 8'h08);
    xin_run = 1'b1;
    put(4, 8'h00);
  endtask

  task automatic t_detect();
    int k;
    put(0, 8'h00);
    put(2, 8'h00);
    put(2, 8'h03); // internal running before arming
    xin_run = 1'b0; // resonator break, no stop instruction while armed
    k = 0;
    while (srst !== 1'b1 && k < 400)
    begin
      idle(1);
      k++;
    end
    chk("stop_rst", srst, 1'b1);
    idle(1);
    chk("ms", ms, 8'h05);
    chk("cm", cm, 8'h80);
    put(2, 8'h03);
    chk("stop_rst", srst, 1'b1);
    xin_run = 1'b1;
    idle(20);
    put(2, 8'h00);
    chk("ms", ms, 8'h00);
  endtask

  // ext clears both bits, the others only the status
  task automatic t_src();
    logic [7:0] ex [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
    for (int s = 0; s < 4; s++)
    begin
      put(2, 8'h01);
      put(8, 8'h00);
      chk("ms", ms, 8'h05);
      put(4 + s, 8'h00);
      chk("ms", ms, ex[s]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // clock, watchdog, main sequence
  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  initial
  begin
    #200000;
    err_total++;
    end_of_test();
  end

  initial
  begin
    err_total = 0;
    comparisons = 0;
    i_rst_n = 1'b0;
    stb = '0;
    wd = '0;
    rb = 3'h2;
    xin_run = 1'b1;
    idle(12);
    i_rst_n = 1'b1;
    t_reset();
    t_lock();
    t_rdiv();
    t_xin();
    t_detect();
    t_src();
    end_of_test();
  end
endmodule // testbench
